// file: ppp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } ppp_fifo_state_type;

  ppp_fifo_state_type st;
  ppp_fifo_state_type next_st;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               push;
  logic               pop;

  assign in_ready  = (st.count != (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = mem[st.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_st.count = st.count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_st.count = st.count - 1'b1;
    end
    if (!rst_n)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    st <= next_st;
    if (push)
    begin
      mem[st.wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// file: ppp_pkg.sv
package ppp_pkg;
  // Data path
  localparam int DATA_W            = 8;
  localparam int CTRL_OUT_W        = 4;
  localparam int CTRL_IN_W         = 8;
  localparam int FIFO_DEPTH        = 8;
  // Control output latch bit positions
  localparam int CO_STROBE_BIT     = 0;
  localparam int CO_INIT_BIT       = 1;
  localparam int CO_AUTO_LF_BIT    = 2;
  localparam int CO_SELECT_BIT     = 3;
  // Control input buffer bit positions
  localparam int CI_ACK_BIT        = 0;
  localparam int CI_BUSY_BIT       = 1;
  localparam int CI_ONLINE_BIT     = 2;
  localparam int CI_FAULT_BIT      = 3;
  localparam int CI_PAPER_BIT      = 4;
  // Reset values
  localparam logic [3:0] CTRL_OUT_RESET = 4'h0;
  // Timing (100 MHz clock)
  localparam int CLK_PERIOD_NS     = 10;
  localparam int SETUP_NS          = 1000;   // data stable before strobe
  localparam int STROBE_NS         = 1000;   // strobe low width
  localparam int INIT_NS           = 50000;  // power-up initialize pulse
  localparam int SETUP_CYC         = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC        = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC          = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 16;
  // Handshake sequencer states
  typedef enum logic [5:0] {
    ST_INIT   = 6'b00_0001,
    ST_IDLE   = 6'b00_0010,
    ST_SETUP  = 6'b00_0100,
    ST_STROBE = 6'b00_1000,
    ST_WAIT   = 6'b01_0000,
    ST_INPUT  = 6'b10_0000
  } ppp_state_type;
endpackage

// file: ppp_port.sv
// Functional notes
// - The port has an 8-bit data output latch, 8-bit data input buffer, 4-bit control output and 8-bit control input.
// - Two direction bits choose whether the data lines are driven or sampled and whether the control lines are driven or released.
// - Data lines drive outgoing bytes normally and are sampled as eight inputs when set to input.
// - Transfers are half duplex, never both directions at once.
// - An active-low strobe marks valid stable data, its falling edge being the reference.
// - The active-low acknowledge from the peripheral ends the current transfer.
// - Busy is active high and reads as asserted when nothing is connected.
// - The active-low initialize output pulses exactly once after power-up.
// - An active-low select-request output is provided to bring the peripheral on-line.
// - The active-high on-line status line is sampled so on-line state can be seen.
// - An interrupt output signals port events to the processor.
// - The port can move bytes at up to 160 kbytes per second.
// - Early boards present input data bit-reversed; corrected boards present it straight.
`timescale 1ns/1ps
`default_nettype none
module ppp_port
  import ppp_pkg::*;
#(
  parameter int INIT_CYCLES   = INIT_CYC,
  parameter bit MIRROR_INPUT  = 1'b0
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          data_dir_in,
  input  wire logic                          ctrl_dir_in,
  input  wire logic                          auto_linefeed_req,
  input  wire logic                          select_req,
  input  wire logic [ppp_pkg::DATA_W-1:0]    tx_data,
  input  wire logic                          tx_valid,
  output logic                               tx_ready,
  output logic [ppp_pkg::DATA_W-1:0]         rx_data,
  output logic                               rx_valid,
  input  wire logic                          rx_take,
  output logic [ppp_pkg::CTRL_IN_W-1:0]      ctrl_status,
  output logic                               irq,
  output logic                               link_idle,
  input  wire logic [ppp_pkg::DATA_W-1:0]    pd_in,
  output logic [ppp_pkg::DATA_W-1:0]         pd_out,
  output logic                               pd_oe,
  output logic [ppp_pkg::CTRL_OUT_W-1:0]     pc_oe,
  output logic                               strobe_n,
  output logic                               init_n,
  output logic                               auto_linefeed_n,
  output logic                               select_request_n,
  input  wire logic                          ack_n,
  input  wire logic                          busy,
  input  wire logic                          online_status,
  input  wire logic                          fault_n,
  input  wire logic                          paper_out
);
  import ppp_pkg::*;

  typedef struct packed {
    ppp_state_type           state;
    logic [CNT_W-1:0]        cnt;
    logic [DATA_W-1:0]       data_lat;
    logic                    data_oe;
    logic                    strobe;
    logic                    init;
    logic                    auto_lf;
    logic                    sel;
    logic [CTRL_OUT_W-1:0]   ctrl_oe;
    logic [DATA_W-1:0]       rx_buf;
    logic                    rx_full;
    logic                    irq;
    logic [DATA_W-1:0]       d_sync1;
    logic [DATA_W-1:0]       d_sync2;
    logic [4:0]              c_sync1;
    logic [4:0]              c_sync2;
    logic                    ack_prev;
    logic [CTRL_IN_W-1:0]    status;
  } ppp_regs_type;

  ppp_regs_type r;
  ppp_regs_type next_r;

  logic              fifo_valid;
  logic              fifo_take;
  logic [DATA_W-1:0] fifo_data;

  function automatic logic [DATA_W-1:0] mirror(input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      m[i] = d[DATA_W-1-i];
    end
    return m;
  endfunction

  ppp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  // Synchronised peripheral inputs
  logic ack_s;
  logic busy_s;
  logic online_s;
  logic fault_s;
  logic paper_s;
  assign {paper_s, fault_s, online_s, busy_s, ack_s} = r.c_sync2;

  assign fifo_take = (r.state == ST_IDLE) && !data_dir_in && !busy_s && fifo_valid;

  always_comb
  begin
    next_r = r;
    next_r.d_sync1  = pd_in;
    next_r.d_sync2  = r.d_sync1;
    next_r.c_sync1  = {paper_out, fault_n, online_status, busy, ack_n};
    next_r.c_sync2  = r.c_sync1;
    next_r.ack_prev = ack_s;
    next_r.irq      = 1'b0;
    next_r.auto_lf  = auto_linefeed_req;
    next_r.sel      = select_req;
    next_r.ctrl_oe  = ctrl_dir_in ? '0 : '1;
    // Status image; an open busy pin must read as busy via the pull-up outside
    next_r.status = '0;
    next_r.status[CI_ACK_BIT]    = !ack_s;
    next_r.status[CI_BUSY_BIT]   = busy_s;
    next_r.status[CI_ONLINE_BIT] = online_s;
    next_r.status[CI_FAULT_BIT]  = !fault_s;
    next_r.status[CI_PAPER_BIT]  = paper_s;
    next_r.status[5]             = r.rx_full;
    next_r.status[6]             = r.state != ST_IDLE;
    next_r.status[7]             = data_dir_in;
    if (rx_take)
    begin
      next_r.rx_full = 1'b0;
    end
    unique case (r.state)
      ST_INIT:
      begin
        // Single initialize pulse after reset
        next_r.init = 1'b1;
        // Compare against the full count so the pin stays low for exactly INIT_CYCLES cycles
        if (r.cnt == CNT_W'(INIT_CYCLES))
        begin
          next_r.init  = 1'b0;
          next_r.cnt   = '0;
          next_r.state = ST_IDLE;
        end
        else
        begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      ST_IDLE:
      begin
        next_r.data_oe = !data_dir_in;
        if (data_dir_in)
        begin
          next_r.state = ST_INPUT;
        end
        else if (fifo_take)
        begin
          next_r.data_lat = fifo_data;
          next_r.cnt      = '0;
          next_r.state    = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == CNT_W'(SETUP_CYC - 1))
        begin
          next_r.strobe = 1'b1;
          next_r.cnt    = '0;
          next_r.state  = ST_STROBE;
        end
      end
      ST_STROBE:
      begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == CNT_W'(STROBE_CYC - 1))
        begin
          next_r.strobe = 1'b0;
          next_r.state  = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // Data stays on the lines until acknowledge closes the cycle
        if (r.ack_prev && !ack_s)
        begin
          next_r.irq   = 1'b1;
          next_r.state = ST_IDLE;
        end
      end
      ST_INPUT:
      begin
        next_r.data_oe = 1'b0;
        if (!data_dir_in)
        begin
          next_r.state = ST_IDLE;
        end
        else if (r.ack_prev && !ack_s && !r.rx_full)
        begin
          next_r.rx_buf  = MIRROR_INPUT ? mirror(r.d_sync2) : r.d_sync2;
          next_r.rx_full = 1'b1;
          next_r.irq     = 1'b1;
        end
      end
      default:
      begin
        next_r.state = ST_IDLE;
      end
    endcase
    if (!rst_n)
    begin
      next_r          = '0;
      next_r.state    = ST_INIT;
      next_r.ctrl_oe  = CTRL_OUT_RESET;
      next_r.ack_prev = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    r <= next_r;
  end

  // Active-low pins come straight from flops
  assign strobe_n         = !r.strobe;
  assign init_n           = !r.init;
  assign auto_linefeed_n  = !r.auto_lf;
  assign select_request_n = !r.sel;
  assign pd_out           = r.data_lat;
  assign pd_oe            = r.data_oe;
  assign pc_oe            = r.ctrl_oe;
  assign rx_data          = r.rx_buf;
  assign rx_valid         = r.rx_full;
  assign ctrl_status      = r.status;
  assign irq              = r.irq;
  // At 100 MHz a byte takes ~2 us plus ack latency, well within 160 kbytes/s
  assign link_idle        = (r.state == ST_IDLE);
endmodule
`default_nettype wire

// file: ppp_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_port_chk #(
  parameter int INIT_CYCLES = ppp_pkg::INIT_CYC
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       data_dir_in,
  input wire logic       ctrl_dir_in,
  input wire logic       rx_valid,
  input wire logic       irq,
  input wire logic       link_idle,
  input wire logic [7:0] pd_out,
  input wire logic       pd_oe,
  input wire logic [3:0] pc_oe,
  input wire logic       strobe_n,
  input wire logic       init_n,
  input wire logic       ack_n,
  input wire logic       busy
);
  import ppp_pkg::*;
  logic [15:0] init_len;
  logic [15:0] strobe_len;
  logic        init_seen;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Low-time counters; repetition operators cannot reach these widths
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      init_len   <= 16'h0000;
      strobe_len <= 16'h0000;
      init_seen  <= 1'b0;
    end
    else
    begin
      init_len   <= init_n ? 16'h0000 : init_len + 16'h0001;
      strobe_len <= strobe_n ? 16'h0000 : strobe_len + 16'h0001;
      init_seen  <= init_seen | !init_n;
    end
  end
  init_once_a: assert property (init_seen && init_n |=> init_n)
    else $error("init pulse repeated");
  init_width_a: assert property ($rose(init_n) |-> init_len == 16'(INIT_CYCLES))
    else $error("init pulse width wrong");
  strobe_width_a: assert property ($rose(strobe_n) |-> strobe_len == 16'(STROBE_CYC))
    else $error("strobe width wrong");
  data_hold_a: assert property (!strobe_n |-> pd_oe && $stable(pd_out))
    else $error("data moved under strobe");
  busy_block_a: assert property ((busy && link_idle && !data_dir_in)[*4] |=> link_idle)
    else $error("transfer started while busy");
  ack_irq_a: assert property ($fell(ack_n) && !link_idle && !rx_valid |-> ##[2:5] irq)
    else $error("ack gave no interrupt");
  irq_cause_a: assert property (irq |-> !$past(ack_n, 2) ##1 !irq)
    else $error("interrupt without ack");
  half_duplex_a: assert property ($rose(rx_valid) |-> !pd_oe)
    else $error("input while driving");
  ctrl_dir_a: assert property ((link_idle && !data_dir_in && $stable(ctrl_dir_in))[*3]
    |-> pc_oe == (ctrl_dir_in ? 4'h0 : 4'hf))
    else $error("control enables wrong");
endmodule
bind ppp_port ppp_port_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.clk, .rst_n, .data_dir_in, .ctrl_dir_in, .rx_valid,
  .irq, .link_idle, .pd_out, .pd_oe, .pc_oe, .strobe_n, .init_n, .ack_n, .busy);
`default_nettype wire

// file: ppp_printer_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_printer_model (
  input  wire logic       clk,
  input  wire logic       strobe_n,
  input  wire logic [7:0] pd_out,
  input  wire logic       pd_oe,
  input  wire logic       attached,
  input  wire logic       paper_gone,
  input  wire logic [7:0] ack_delay,
  input  wire logic       send,
  input  wire logic [7:0] send_byte,
  output logic      [7:0] pd_in,
  output logic      [7:0] got,
  output logic            ack_n,
  output logic            busy,
  output logic            online_status,
  output logic            fault_n,
  output logic            paper_out
);
  logic       strobe_q = 1'b1;
  logic       busy_q = 1'b0;
  logic [8:0] cnt = 9'h000;
  logic [7:0] sq = 8'h00;
  always_ff @(posedge clk)
  begin
    strobe_q <= strobe_n;
    if (strobe_q && !strobe_n)
    begin
      got    <= pd_out;
      busy_q <= 1'b1;
    end
    // Ack only after the strobe ends, as the port waits for it then
    if (!strobe_q && strobe_n)
      cnt <= 9'(ack_delay) + 9'd12;
    else if (send)
    begin
      cnt <= 9'd12;
      sq  <= send_byte;
    end
    else if (cnt != 9'd0)
      cnt <= cnt - 9'd1;
    if (cnt == 9'd1)
      busy_q <= 1'b0;
  end
  assign ack_n = !(cnt != 9'd0 && cnt <= 9'd10);
  assign busy = busy_q || !attached;
  assign online_status = attached;
  assign paper_out = paper_gone;
  assign fault_n = !paper_gone;
  // Released lines show the inverse so a stale byte cannot pass
  assign pd_in = pd_oe ? pd_out : (cnt != 9'd0 ? sq : ~sq);
endmodule
`default_nettype wire

// file: tb_ppp_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ppp_port;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       data_dir_in = 1'b0;
  logic       ctrl_dir_in = 1'b0;
  logic       auto_linefeed_req = 1'b0;
  logic       select_req = 1'b0;
  logic       tx_valid = 1'b0;
  logic       rx_take = 1'b0;
  logic       attached = 1'b0;
  logic       paper_gone = 1'b0;
  logic       send = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] ack_delay = 8'h00;
  logic [7:0] send_byte = 8'h00;
  logic       tx_ready, rx_valid, irq, link_idle, pd_oe, strobe_n, init_n, auto_linefeed_n, select_request_n;
  logic       ack_n, busy, online_status, fault_n, paper_out;
  logic [7:0] rx_data, ctrl_status, pd_in, pd_out, got;
  logic [3:0] pc_oe;
  int         err_count = 0;
  int         checks = 0;
  int         cycles = 0;
  int         n;
  ppp_port #(.INIT_CYCLES(20), .MIRROR_INPUT(1'b0)) dut (.clk, .rst_n, .data_dir_in, .ctrl_dir_in,
    .auto_linefeed_req, .select_req, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_take, .ctrl_status,
    .irq, .link_idle, .pd_in, .pd_out, .pd_oe, .pc_oe, .strobe_n, .init_n, .auto_linefeed_n, .select_request_n,
    .ack_n, .busy, .online_status, .fault_n, .paper_out);
  ppp_printer_model model (.clk, .strobe_n, .pd_out, .pd_oe, .attached, .paper_gone, .ack_delay, .send, .send_byte,
    .pd_in, .got, .ack_n, .busy, .online_status, .fault_n, .paper_out);
  always #5 clk = ~clk;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic send_in(input logic [7:0] b);
    tick(12);
    send_byte <= b;
    send      <= 1'b1;
    tick(1);
    send      <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      err_count++;
      finish_test();
    end
  end
  initial
  begin
    tick(3);
    rst_n <= 1'b1;
    do @(posedge clk); while (init_n !== 1'b0);
    n = 0;
    while (init_n === 1'b0)
    begin
      @(posedge clk);
      n++;
    end
    check("init width", 8'(n), 8'd20);
    // Status image lags the sequencer by one edge; let it see the idle state
    tick(1);
    check("ctrl enables", 8'(pc_oe), 8'h0f);
    check("status unplugged", ctrl_status, 8'h02);
    $display("test init done");
    // Unplugged peripheral reads busy, so the FIFO must fill untouched
    for (int i = 0; i < 8; i++)
    begin
      tx_data  <= 8'(1 << i);
      tx_valid <= 1'b1;
      do @(posedge clk); while (tx_ready !== 1'b1);
    end
    tx_valid <= 1'b0;
    tick(2);
    check("fifo full", 8'(tx_ready), 8'h00);
    check("no strobe", 8'(strobe_n), 8'h01);
    $display("test fill done");
    attached <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      ack_delay <= 8'(i * 20);
      do @(posedge clk); while (irq !== 1'b1);
      check("printed", got, 8'(1 << i));
    end
    $display("test drain done");
    paper_gone        <= 1'b1;
    auto_linefeed_req <= 1'b1;
    select_req        <= 1'b1;
    tick(20);
    check("status", {3'h0, ctrl_status[4:0]}, 8'h1c);
    check("lines", {6'h00, auto_linefeed_n, select_request_n}, 8'h00);
    paper_gone        <= 1'b0;
    auto_linefeed_req <= 1'b0;
    select_req        <= 1'b0;
    ctrl_dir_in       <= 1'b1;
    tick(6);
    check("ctrl released", 8'(pc_oe), 8'h00);
    ctrl_dir_in <= 1'b0;
    $display("test control done");
    data_dir_in <= 1'b1;
    tick(6);
    check("data released", 8'(pd_oe), 8'h00);
    send_in(8'ha5);
    do @(posedge clk); while (rx_valid !== 1'b1);
    check("input byte", rx_data, 8'ha5);
    send_in(8'h3c);
    tick(20);
    check("dropped", rx_data, 8'ha5);
    rx_take <= 1'b1;
    tick(1);
    rx_take <= 1'b0;
    tick(3);
    check("taken", 8'(rx_valid), 8'h00);
    $display("test input done");
    finish_test();
  end
endmodule
`default_nettype wire
